// ==== alu_consts.svh ====
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

`define ALU_NIBBLE_W 4
`define ALU_BYTE_W 8
`define ALU_WORD_W 16
`define ALU_DWORD_W 32
`define ALU_BYTE_MSB 7
`define ALU_WORD_MSB 15
`define ALU_BCD_NINE 4'h9
`define ALU_BCD_SIX 4'h6
`define ALU_DIV_BYTE_STEPS 5'h08
`define ALU_DIV_WORD_STEPS 5'h10
`define ALU_ZERO_BYTE 8'h00
`define ALU_ZERO_WORD 16'h0000
`define ALU_MSB_SET_BYTE 8'h80

`endif

// ==== alu_pkg.sv ====
package alu_pkg;

  typedef enum logic [4:0] {
    op_add,
    op_sub,
    add_no_flags,
    subtract_no_flags,
    add_with_carry,
    subtract_with_borrow,
    decimal_add,
    decimal_subtract,
    unsigned_multiply,
    unsigned_divide,
    compare_op,
    sign_extend_byte,
    zero_extend_byte,
    test_against_zero,
    op_negate,
    clear_operand,
    test_and_set_msb,
    op_and,
    op_or,
    op_xor,
    op_not
  } alu_op_t;

  typedef enum logic {
    st_idle,
    st_divide
  } alu_state_t;

endpackage : alu_pkg

// ==== decimal_adjust_unit.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"

module decimal_adjust_unit
(
  input wire logic [`ALU_BYTE_W-1:0] dst_byte,
  input wire logic [`ALU_BYTE_W-1:0] src_byte,
  input wire logic carry_in,
  input wire logic subtract,
  output logic [`ALU_BYTE_W-1:0] result,
  output logic carry_out
);
  localparam int DIGITS = `ALU_BYTE_W / `ALU_NIBBLE_W;

  wire [DIGITS:0] chain;

  assign chain[0] = carry_in;

  // Each digit ripples its decimal carry or borrow into the next one.
  for (genvar g = 0; g < DIGITS; g++)
  begin : g_digit
    wire [`ALU_NIBBLE_W-1:0] da = dst_byte[g*`ALU_NIBBLE_W +: `ALU_NIBBLE_W];
    wire [`ALU_NIBBLE_W-1:0] db = src_byte[g*`ALU_NIBBLE_W +: `ALU_NIBBLE_W];
    wire [`ALU_NIBBLE_W:0] sum_raw = {1'b0, da} + {1'b0, db} + {4'h0, chain[g]};
    wire [`ALU_NIBBLE_W:0] dif_raw = {1'b0, da} - {1'b0, db} - {4'h0, chain[g]};
    wire add_fix = sum_raw > {1'b0, `ALU_BCD_NINE};

    assign chain[g+1] = subtract ? dif_raw[`ALU_NIBBLE_W] : add_fix;
    assign result[g*`ALU_NIBBLE_W +: `ALU_NIBBLE_W] = subtract ?
      (dif_raw[`ALU_NIBBLE_W] ? dif_raw[3:0] - `ALU_BCD_SIX : dif_raw[3:0]) :
      (add_fix ? sum_raw[3:0] + `ALU_BCD_SIX : sum_raw[3:0]);
  end

  assign carry_out = chain[DIGITS];

endmodule : decimal_adjust_unit

// ==== unsigned_divider.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"

module unsigned_divider
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic word_mode,
  input wire logic [`ALU_DWORD_W-1:0] dividend,
  input wire logic [`ALU_WORD_W-1:0] divisor,
  output logic done,
  output logic [`ALU_WORD_W-1:0] quotient,
  output logic [`ALU_WORD_W-1:0] remainder
);
  logic [`ALU_WORD_W-1:0] div_reg;
  logic [4:0] steps_left;
  logic running;
  logic [`ALU_WORD_W:0] shifted;
  logic fits;

  // One restoring step a cycle keeps the datapath to a single subtractor.
  assign shifted = {remainder, quotient[`ALU_WORD_MSB]};
  assign fits = shifted >= {1'b0, div_reg};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      running <= 1'b0;
      done <= 1'b0;
      steps_left <= 5'h00;
      div_reg <= `ALU_ZERO_WORD;
      quotient <= `ALU_ZERO_WORD;
      remainder <= `ALU_ZERO_WORD;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start && !running)
      begin
        running <= 1'b1;
        if (word_mode)
        begin
          div_reg <= divisor;
          remainder <= dividend[`ALU_DWORD_W-1:`ALU_WORD_W];
          quotient <= dividend[`ALU_WORD_W-1:0];
          steps_left <= `ALU_DIV_WORD_STEPS;
        end
        else
        begin
          div_reg <= {`ALU_ZERO_BYTE, divisor[`ALU_BYTE_W-1:0]};
          remainder <= {`ALU_ZERO_BYTE, dividend[`ALU_WORD_W-1:`ALU_BYTE_W]};
          quotient <= {dividend[`ALU_BYTE_W-1:0], `ALU_ZERO_BYTE};
          steps_left <= `ALU_DIV_BYTE_STEPS;
        end
      end
      else if (running)
      begin
        remainder <= fits ? shifted[`ALU_WORD_W-1:0] - div_reg : shifted[`ALU_WORD_W-1:0];
        quotient <= {quotient[`ALU_WORD_W-2:0], fits};
        steps_left <= steps_left - 5'h01;
        if (steps_left == 5'h01)
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule : unsigned_divider

// ==== cpu_arith_logic_unit.sv ====
`timescale 1ns/1ps
`include "alu_consts.svh"

// What this block does
// - Add or subtract source to destination, byte or word, result written back.
// - Extended add and subtract fold the carry flag in as carry or borrow.
// - Decimal add and subtract on packed BCD bytes with carry, corrected result.
// - Unsigned multiply byte by byte or word by word, product to destination.
// - Unsigned divide 16 by 8 or 32 by 16, results to destination.
// - Compare subtracts operand, updates flags only, operands left unchanged.
// - Sign extend copies bit 7 into the upper eight bits.
// - Zero extend forces the upper eight bits to zero.
// - Test compares operand with zero, flags only, operand untouched.
// - Negate replaces operand with zero minus operand.
// - Clear writes zero to the operand, byte or word.
// - Test and set flags the operand against zero, then sets bit 7.
// - AND combines register with operand bitwise, result to register.
// - OR combines register with operand bitwise, result to register.
// - XOR combines register with operand bitwise, result to register.
// - Complement inverts every bit of the operand.
module cpu_arith_logic_unit
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire alu_pkg::alu_op_t op_sel,
  input wire logic size_word,
  input wire logic [`ALU_DWORD_W-1:0] dst_value,
  input wire logic [`ALU_WORD_W-1:0] src_value,
  input wire logic carry_in,
  output logic op_ready,
  output logic done,
  output logic result_write,
  output logic [`ALU_DWORD_W-1:0] result_data,
  output logic flags_write,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  output logic flag_c
);
  import alu_pkg::*;

  alu_state_t state;
  logic take;
  logic div_fault;
  logic div_start;
  logic div_done;
  logic [`ALU_WORD_W-1:0] div_quotient;
  logic [`ALU_WORD_W-1:0] div_remainder;
  logic div_word;

  logic [`ALU_WORD_W-1:0] dst_fit;
  logic [`ALU_WORD_W-1:0] src_fit;
  logic [`ALU_WORD_W-1:0] add_a;
  logic [`ALU_WORD_W-1:0] add_b;
  logic add_cin;
  logic add_is_sub;
  logic [`ALU_WORD_W:0] add_sum;
  logic [`ALU_WORD_W-1:0] add_res;
  logic add_carry;
  logic add_overflow;
  logic [`ALU_BYTE_W-1:0] bcd_res;
  logic bcd_carry;
  logic [`ALU_DWORD_W-1:0] product;
  logic [`ALU_WORD_W-1:0] logic_res;

  logic [`ALU_DWORD_W-1:0] next_result;
  logic next_write;
  logic next_flags_write;
  logic next_n;
  logic next_z;
  logic next_v;
  logic next_c;

  // Clears the upper byte when the operation is byte sized.
  function automatic logic [`ALU_WORD_W-1:0] fit_size(input logic [`ALU_WORD_W-1:0] v,
                                                     input logic word);
    fit_size = word ? v : {`ALU_ZERO_BYTE, v[`ALU_BYTE_W-1:0]};
  endfunction : fit_size

  function automatic logic top_bit(input logic [`ALU_WORD_W-1:0] v, input logic word);
    top_bit = word ? v[`ALU_WORD_MSB] : v[`ALU_BYTE_MSB];
  endfunction : top_bit

  // A byte result lands in the low byte; the register keeps its upper byte.
  function automatic logic [`ALU_DWORD_W-1:0] place(input logic [`ALU_WORD_W-1:0] v,
                                                   input logic [`ALU_WORD_W-1:0] dst,
                                                   input logic word);
    place = word ? {`ALU_ZERO_WORD, v} :
      {`ALU_ZERO_WORD, dst[`ALU_WORD_W-1:`ALU_BYTE_W], v[`ALU_BYTE_W-1:0]};
  endfunction : place

  assign op_ready = (state == st_idle);
  assign take = op_valid && op_ready && clk_en;
  assign dst_fit = fit_size(dst_value[`ALU_WORD_W-1:0], size_word);
  assign src_fit = fit_size(src_value, size_word);

  // Adder operand selection shared by every add and subtract form but the decimal ones.
  always_comb
  begin
    add_a = dst_fit;
    add_b = src_fit;
    add_cin = 1'b0;
    add_is_sub = 1'b0;
    case (op_sel)
      op_sub, subtract_no_flags, compare_op:
      begin
        add_b = fit_size(~src_value, size_word);
        add_cin = 1'b1;
        add_is_sub = 1'b1;
      end
      add_with_carry:
      begin
        add_cin = carry_in;
      end
      subtract_with_borrow:
      begin
        add_b = fit_size(~src_value, size_word);
        add_cin = ~carry_in;
        add_is_sub = 1'b1;
      end
      op_negate:
      begin
        add_a = `ALU_ZERO_WORD;
        add_b = fit_size(~dst_value[`ALU_WORD_W-1:0], size_word);
        add_cin = 1'b1;
        add_is_sub = 1'b1;
      end
      default:
      begin
        add_cin = 1'b0;
      end
    endcase
  end

  assign add_sum = {1'b0, add_a} + {1'b0, add_b} + {`ALU_ZERO_WORD, add_cin};
  assign add_res = fit_size(add_sum[`ALU_WORD_W-1:0], size_word);
  assign add_carry = (size_word ? add_sum[`ALU_WORD_W] : add_sum[`ALU_BYTE_W]) ^ add_is_sub;
  assign add_overflow = (top_bit(add_a, size_word) == top_bit(add_b, size_word)) &&
                        (top_bit(add_res, size_word) != top_bit(add_a, size_word));

  decimal_adjust_unit u_decimal
  (
    .dst_byte(dst_value[`ALU_BYTE_W-1:0]),
    .src_byte(src_value[`ALU_BYTE_W-1:0]),
    .carry_in(carry_in),
    .subtract(op_sel == decimal_subtract),
    .result(bcd_res),
    .carry_out(bcd_carry)
  );

  assign product = size_word ?
    {`ALU_ZERO_WORD, dst_value[`ALU_WORD_W-1:0]} * {`ALU_ZERO_WORD, src_value} :
    {`ALU_ZERO_WORD, `ALU_ZERO_BYTE, dst_value[`ALU_BYTE_W-1:0]} *
    {`ALU_ZERO_WORD, `ALU_ZERO_BYTE, src_value[`ALU_BYTE_W-1:0]};

  // A quotient that cannot fit, or a zero divisor, is refused before any step runs.
  assign div_fault = size_word ?
    (src_value == `ALU_ZERO_WORD) || (dst_value[`ALU_DWORD_W-1:`ALU_WORD_W] >= src_value) :
    (src_value[`ALU_BYTE_W-1:0] == `ALU_ZERO_BYTE) ||
    (dst_value[`ALU_WORD_W-1:`ALU_BYTE_W] >= src_value[`ALU_BYTE_W-1:0]);
  assign div_start = take && (op_sel == unsigned_divide) && !div_fault;

  // Logic results clear overflow and keep the carry the caller supplied.
  assign logic_res = (op_sel == op_and) ? (dst_fit & src_fit) :
                     (op_sel == op_or) ? (dst_fit | src_fit) :
                     (op_sel == op_xor) ? (dst_fit ^ src_fit) :
                     fit_size(~dst_value[`ALU_WORD_W-1:0], size_word);

  unsigned_divider u_divider
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(div_start),
    .word_mode(size_word),
    .dividend(dst_value),
    .divisor(src_value),
    .done(div_done),
    .quotient(div_quotient),
    .remainder(div_remainder)
  );

  // Result and flags for every single-cycle operation.
  always_comb
  begin
    next_result = place(add_res, dst_value[`ALU_WORD_W-1:0], size_word);
    next_write = 1'b1;
    next_flags_write = 1'b1;
    next_n = top_bit(add_res, size_word);
    next_z = (add_res == `ALU_ZERO_WORD);
    next_v = add_overflow;
    next_c = add_carry;
    case (op_sel)
      op_add, op_sub, add_with_carry, subtract_with_borrow, op_negate:
      begin
        next_write = 1'b1;
      end
      add_no_flags, subtract_no_flags:
      begin
        next_flags_write = 1'b0;
      end
      compare_op:
      begin
        next_write = 1'b0;
      end
      decimal_add, decimal_subtract:
      begin
        next_result = place({`ALU_ZERO_BYTE, bcd_res}, dst_value[`ALU_WORD_W-1:0], 1'b0);
        next_n = bcd_res[`ALU_BYTE_MSB];
        next_z = (bcd_res == `ALU_ZERO_BYTE);
        next_v = 1'b0;
        next_c = bcd_carry;
      end
      unsigned_multiply:
      begin
        next_result = size_word ? product :
          {`ALU_ZERO_WORD, product[`ALU_WORD_W-1:0]};
        next_n = size_word ? product[`ALU_DWORD_W-1] : product[`ALU_WORD_MSB];
        next_z = (product == {`ALU_ZERO_WORD, `ALU_ZERO_WORD});
        next_v = 1'b0;
        next_c = 1'b0;
      end
      unsigned_divide:
      begin
        next_result = dst_value;
        next_write = 1'b0;
        next_n = 1'b0;
        next_z = 1'b0;
        next_v = 1'b1;
        next_c = 1'b0;
      end
      sign_extend_byte, zero_extend_byte:
      begin
        next_result = {`ALU_ZERO_WORD,
          {`ALU_BYTE_W{(op_sel == sign_extend_byte) && dst_value[`ALU_BYTE_MSB]}},
          dst_value[`ALU_BYTE_W-1:0]};
        next_n = (op_sel == sign_extend_byte) && dst_value[`ALU_BYTE_MSB];
        next_z = (dst_value[`ALU_BYTE_W-1:0] == `ALU_ZERO_BYTE);
        next_v = 1'b0;
        next_c = 1'b0;
      end
      test_against_zero, test_and_set_msb:
      begin
        next_write = (op_sel == test_and_set_msb);
        next_result = place(dst_fit | {`ALU_ZERO_BYTE, `ALU_MSB_SET_BYTE},
                            dst_value[`ALU_WORD_W-1:0], size_word);
        next_n = top_bit(dst_fit, size_word);
        next_z = (dst_fit == `ALU_ZERO_WORD);
        next_v = 1'b0;
        next_c = 1'b0;
      end
      clear_operand:
      begin
        next_result = place(`ALU_ZERO_WORD, dst_value[`ALU_WORD_W-1:0], size_word);
        next_n = 1'b0;
        next_z = 1'b1;
        next_v = 1'b0;
        next_c = 1'b0;
      end
      op_and, op_or, op_xor, op_not:
      begin
        next_result = place(logic_res, dst_value[`ALU_WORD_W-1:0], size_word);
        next_n = top_bit(logic_res, size_word);
        next_z = (logic_res == `ALU_ZERO_WORD);
        next_v = 1'b0;
        next_c = carry_in;
      end
      default:
      begin
        next_write = 1'b0;
        next_flags_write = 1'b0;
      end
    endcase
  end

  // The decoder must hold the request steady only in the cycle it is taken.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= st_idle;
      div_word <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state)
        st_idle:
        begin
          if (div_start)
          begin
            state <= st_divide;
            div_word <= size_word;
          end
        end
        st_divide:
        begin
          if (div_done)
          begin
            state <= st_idle;
          end
        end
        default:
        begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      result_write <= 1'b0;
      flags_write <= 1'b0;
      result_data <= {`ALU_ZERO_WORD, `ALU_ZERO_WORD};
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_v <= 1'b0;
      flag_c <= 1'b0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      result_write <= 1'b0;
      flags_write <= 1'b0;
      if (take && !div_start)
      begin
        done <= 1'b1;
        result_write <= next_write;
        flags_write <= next_flags_write;
        result_data <= next_result;
        if (next_flags_write)
        begin
          flag_n <= next_n;
          flag_z <= next_z;
          flag_v <= next_v;
          flag_c <= next_c;
        end
      end
      else if ((state == st_divide) && div_done)
      begin
        done <= 1'b1;
        result_write <= 1'b1;
        flags_write <= 1'b1;
        result_data <= div_word ? {div_remainder, div_quotient} :
          {`ALU_ZERO_WORD, div_remainder[`ALU_BYTE_W-1:0],
           div_quotient[`ALU_BYTE_W-1:0]};
        flag_n <= div_word ? div_quotient[`ALU_WORD_MSB] : div_quotient[`ALU_BYTE_MSB];
        flag_z <= div_word ? (div_quotient == `ALU_ZERO_WORD) :
          (div_quotient[`ALU_BYTE_W-1:0] == `ALU_ZERO_BYTE);
        flag_v <= 1'b0;
        flag_c <= 1'b0;
      end
    end
  end

endmodule : cpu_arith_logic_unit

// ==== alu_props.sv ====
`timescale 1ns/1ps
module alu_props
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire alu_pkg::alu_op_t op_sel,
  input wire logic size_word,
  input wire logic [31:0] dst_value,
  input wire logic [15:0] src_value,
  input wire logic carry_in,
  input wire logic op_ready,
  input wire logic done,
  input wire logic result_write,
  input wire logic [31:0] result_data,
  input wire logic flags_write,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_v,
  input wire logic flag_c
);
  import alu_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic take;
  logic take_q;
  alu_op_t op_q;
  logic size_q;
  logic [31:0] dst_q;
  logic [15:0] src_q;
  assign take = op_valid && op_ready && clk_en;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      take_q <= 1'h0;
    else
      take_q <= take && op_sel != unsigned_divide;
  end
  always_ff @(posedge clk_sys)
  begin
    if (take)
    begin
      op_q <= op_sel;
      size_q <= size_word;
      dst_q <= dst_value;
      src_q <= src_value;
    end
  end
  // A divide is only legal when the quotient fits; the others answer at once.
  sequence div_b;
    take && op_sel == unsigned_divide && !size_word && src_value[7:0] != 8'h00
      && dst_value[15:8] < src_value[7:0];
  endsequence
  sequence div_w;
    take && op_sel == unsigned_divide && size_word && src_value != 16'h0000
      && dst_value[31:16] < src_value;
  endsequence
  one_cycle_a: assert property (take_q |-> done) else $error("single op late");
  byte_div_a: assert property (div_b |=> !op_ready [*8] ##1 !op_ready ##1 (done && result_write))
    else $error("byte divide timing");
  word_div_a: assert property (div_w |=> !op_ready ##16 !op_ready ##1 done)
    else $error("word divide timing");
  cmp_nowrite_a: assert property (take_q && op_q == compare_op |-> !result_write
    && flags_write) else $error("compare wrote");
  flags_hold_a: assert property (!flags_write |-> $stable({flag_n, flag_z, flag_v, flag_c}))
    else $error("flags moved");
  data_hold_a: assert property (!done |-> $stable(result_data)) else $error("data moved");
  sign_ext_a: assert property (take_q && op_q == sign_extend_byte |->
    result_data[15:0] == {{8{dst_q[7]}}, dst_q[7:0]}) else $error("sign extend");
  tas_set_a: assert property (take_q && op_q == test_and_set_msb |->
    result_data[7:0] == (dst_q[7:0] | 8'h80) && flag_z == (dst_q[7:0] == 8'h00))
    else $error("test and set");
  neg_word_a: assert property (take_q && op_q == op_negate && size_q |->
    result_data[15:0] == 16'h0000 - dst_q[15:0]) else $error("negate");
  xor_word_a: assert property (take_q && op_q == op_xor && size_q |->
    result_data[15:0] == (dst_q[15:0] ^ src_q)) else $error("xor");
  cover property (div_w);
  cover property (take_q && op_q == decimal_add);
  cover property (take_q ##1 take_q ##1 take_q);
endmodule : alu_props

bind cpu_arith_logic_unit alu_props chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .op_valid(op_valid), .op_sel(op_sel), .size_word(size_word), .dst_value(dst_value),
  .src_value(src_value), .carry_in(carry_in), .op_ready(op_ready), .done(done),
  .result_write(result_write), .result_data(result_data), .flags_write(flags_write),
  .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v), .flag_c(flag_c));

// ==== decode_model.sv ====
`timescale 1ns/1ps
module decode_model
(
  input wire logic clk_sys,
  input wire logic op_ready,
  input wire logic result_write,
  input wire logic [31:0] result_data,
  output logic clk_en,
  output logic op_valid,
  output alu_pkg::alu_op_t op_sel,
  output logic size_word,
  output logic [31:0] dst_value,
  output logic [15:0] src_value,
  output logic carry_in
);
  import alu_pkg::*;
  logic [31:0] reg_value = 32'h0;
  initial
  begin
    clk_en = 1'h1;
    op_valid = 1'h0;
    op_sel = op_add;
    size_word = 1'h0;
    dst_value = 32'h0;
    src_value = 16'h0;
    carry_in = 1'h0;
  end
  always @(posedge clk_sys)
  begin
    if (result_write === 1'h1)
      reg_value <= result_data;
  end
  // Operands stand whole from the falling edge until the taking edge.
  task issue(input alu_op_t op, input logic w, input logic [31:0] d, input logic [15:0] s,
    input logic c);
    @(negedge clk_sys);
    op_sel = op;
    size_word = w;
    dst_value = d;
    src_value = s;
    carry_in = c;
    op_valid = 1'h1;
    while (op_ready !== 1'h1)
      @(negedge clk_sys);
    @(posedge clk_sys);
  endtask : issue
  // Released operands are inverted so a stale value cannot pass by luck.
  task idle;
    op_valid = 1'h0;
    dst_value = ~dst_value;
    src_value = ~src_value;
  endtask : idle
endmodule : decode_model

// ==== cpu_arith_logic_unit_test.sv ====
`timescale 1ns/1ps
module cpu_arith_logic_unit_test;
  import alu_pkg::*;
  logic clk_sys, rst_n, clk_en, op_valid, size_word, carry_in, op_ready, done;
  logic result_write, flags_write, flag_n, flag_z, flag_v, flag_c;
  alu_op_t op_sel;
  logic [31:0] dst_value, result_data;
  logic [15:0] src_value;
  int n_errors = 0;
  int n_tests = 0;
  int n_done = 0;
  int cycles = 0;
  int last_wait;
  cpu_arith_logic_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_sel(op_sel), .size_word(size_word), .dst_value(dst_value),
    .src_value(src_value), .carry_in(carry_in), .op_ready(op_ready), .done(done),
    .result_write(result_write), .result_data(result_data), .flags_write(flags_write),
    .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v), .flag_c(flag_c));
  decode_model dec (.clk_sys(clk_sys), .op_ready(op_ready), .result_write(result_write),
    .result_data(result_data), .clk_en(clk_en), .op_valid(op_valid), .op_sel(op_sel),
    .size_word(size_word), .dst_value(dst_value), .src_value(src_value),
    .carry_in(carry_in));
  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    n_done = n_done + (done === 1'h1);
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task run(input alu_op_t op, input logic w, input logic [31:0] d, input logic [15:0] s,
    input logic c, input logic wr, input logic [31:0] er, input logic [3:0] ef,
    input logic [3:0] m);
    dec.issue(op, w, d, s, c);
    @(negedge clk_sys);
    dec.idle();
    last_wait = 0;
    while (done !== 1'h1 && last_wait < 40)
    begin
      @(negedge clk_sys);
      last_wait++;
    end
    check("done", {31'h0, done}, 32'h1);
    check("write", {31'h0, result_write}, {31'h0, wr});
    if (wr)
      check("result", result_data, er);
    check("flags", {28'h0, {flag_n, flag_z, flag_v, flag_c} & m}, {28'h0, ef & m});
  endtask : run
  task t_arith;
    run(op_add, 1'h1, 32'h7FFF, 16'h1, 1'h0, 1'h1, 32'h8000, 4'hA, 4'hF);
    run(op_sub, 1'h0, 32'h3400, 16'h1, 1'h0, 1'h1, 32'h34FF, 4'h9, 4'hF);
    run(add_with_carry, 1'h0, 32'hFF, 16'h0, 1'h1, 1'h1, 32'h0, 4'h5, 4'hF);
    run(subtract_with_borrow, 1'h1, 32'h0, 16'h0, 1'h1, 1'h1, 32'hFFFF, 4'h9, 4'hF);
    run(decimal_add, 1'h0, 32'h19, 16'h28, 1'h1, 1'h1, 32'h48, 4'h0, 4'h1);
    run(decimal_add, 1'h0, 32'h99, 16'h01, 1'h0, 1'h1, 32'h00, 4'h1, 4'h1);
    run(decimal_subtract, 1'h0, 32'h10, 16'h01, 1'h0, 1'h1, 32'h09, 4'h0, 4'h1);
    $display("test arith done");
  endtask : t_arith
  task t_muldiv;
    run(unsigned_multiply, 1'h0, 32'hFF, 16'hFF, 1'h0, 1'h1, 32'hFE01, 4'h8, 4'hF);
    run(unsigned_multiply, 1'h1, 32'hFFFF, 16'h2, 1'h0, 1'h1, 32'h1FFFE, 4'h0, 4'hF);
    run(unsigned_divide, 1'h0, 32'h64, 16'h7, 1'h0, 1'h1, 32'h020E, 4'h0, 4'hF);
    check("byte wait", last_wait, 32'h9);
    run(unsigned_divide, 1'h1, 32'h12345, 16'h100, 1'h0, 1'h1, 32'h450123, 4'h0, 4'hF);
    check("word wait", last_wait, 32'h11);
    run(unsigned_divide, 1'h0, 32'h64, 16'h0, 1'h0, 1'h0, 32'h0, 4'h2, 4'hF);
    $display("test muldiv done");
  endtask : t_muldiv
  task t_flagonly;
    run(compare_op, 1'h1, 32'h5, 16'h5, 1'h0, 1'h0, 32'h0, 4'h4, 4'hF);
    run(test_against_zero, 1'h0, 32'h80, 16'h0, 1'h0, 1'h0, 32'h0, 4'h8, 4'hF);
    $display("test flagonly done");
  endtask : t_flagonly
  task t_unary;
    run(sign_extend_byte, 1'h0, 32'h0085, 16'h0, 1'h0, 1'h1, 32'hFF85, 4'h8, 4'hC);
    run(zero_extend_byte, 1'h0, 32'hAB85, 16'h0, 1'h0, 1'h1, 32'h0085, 4'h0, 4'hC);
    run(op_negate, 1'h1, 32'h1, 16'h0, 1'h0, 1'h1, 32'hFFFF, 4'h9, 4'hF);
    run(clear_operand, 1'h0, 32'h12FF, 16'h0, 1'h1, 1'h1, 32'h1200, 4'h4, 4'hF);
    run(test_and_set_msb, 1'h0, 32'h5600, 16'h0, 1'h0, 1'h1, 32'h5680, 4'h4, 4'hC);
    run(op_not, 1'h1, 32'hF0F0, 16'h0, 1'h1, 1'h1, 32'h0F0F, 4'h1, 4'hF);
    $display("test unary done");
  endtask : t_unary
  task t_logic;
    run(op_and, 1'h1, 32'hF0F0, 16'hFF00, 1'h1, 1'h1, 32'hF000, 4'h9, 4'hF);
    run(op_or, 1'h1, 32'hF0F0, 16'hFF00, 1'h1, 1'h1, 32'hFFF0, 4'h9, 4'hF);
    run(op_xor, 1'h1, 32'hF0F0, 16'hFF00, 1'h0, 1'h1, 32'h0FF0, 4'h0, 4'hF);
    $display("test logic done");
  endtask : t_logic
  task t_b2b;
    logic [3:0] f0;
    int d0;
    @(negedge clk_sys);
    f0 = {flag_n, flag_z, flag_v, flag_c};
    d0 = n_done;
    dec.issue(add_no_flags, 1'h1, 32'h1, 16'h1, 1'h0);
    dec.issue(subtract_no_flags, 1'h1, 32'h10, 16'h1, 1'h0);
    dec.issue(add_no_flags, 1'h1, 32'hFFFF, 16'h1, 1'h0);
    @(negedge clk_sys);
    dec.idle();
    repeat (3) @(negedge clk_sys);
    check("b2b count", 32'(n_done - d0), 32'h3);
    check("write back", dec.reg_value, 32'h0);
    check("flags kept", {28'h0, flag_n, flag_z, flag_v, flag_c}, {28'h0, f0});
    $display("test b2b done");
  endtask : t_b2b
  task t_hold;
    int d0;
    @(negedge clk_sys);
    d0 = n_done;
    dec.clk_en = 1'h0;
    dec.issue(op_add, 1'h1, 32'h1, 16'h1, 1'h0);
    repeat (3) @(negedge clk_sys);
    check("held count", 32'(n_done - d0), 32'h0);
    check("held done", {31'h0, done}, 32'h0);
    dec.clk_en = 1'h1;
    @(negedge clk_sys);
    dec.idle();
    check("released", {31'h0, done}, 32'h1);
    check("released sum", result_data, 32'h2);
    $display("test hold done");
  endtask : t_hold
  task results;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    rst_n = 1'h0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'h1;
    t_arith();
    t_muldiv();
    t_flagonly();
    t_unary();
    t_logic();
    t_b2b();
    t_hold();
    results();
  end
endmodule : cpu_arith_logic_unit_test
